// ### src/oag_addr_gen.sv
// Notes on behaviour
// - Seventeen addressing modes in seven groups.
// - Inherent: opcode only, no operand bytes.
// - Immediate: one operand byte used as value.
// - Short direct: one address byte, page zero.
// - Long direct: two address bytes, full space.
// - Indexed address is unsigned index plus offset.
// - No-offset indexed: no byte, index alone.
// - Short indexed: one offset byte, up to 1FE.
// - Long indexed: two offset bytes, full space.
// - Short indirect: byte pointer read from page zero.
// - Long indirect: word pointer read, full space.
// - Indirect indexed adds index to pointer value.
// - Short indirect indexed reaches up to 1FE.
// - Relative adds signed byte offset to PC.
// - Memory-to-memory ops only in short modes.
// - Set mask gives level 3, clear gives 0.
// - Prefix 90h swaps X for Y.
// - Prefix 92h turns direct into indirect.
// - Prefix 91h gives indirect indexed by Y.
`timescale 1ns/10ps
module oag_addr_gen (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             arst_n,
    // Instruction from the opcode decoder.
    input  wire logic             req_valid,
    output logic                  req_ready,
    input  wire oag_pkg::oag_req_s req,
    // Memory read port.
    output logic                  mem_req,
    output logic [15:0]           mem_addr,
    input  wire logic [7:0]       mem_rdata,
    input  wire logic             mem_ack,
    // Result and interrupt mask level.
    output logic                  res_valid,
    output oag_pkg::oag_res_s     res,
    output logic [1:0]            irq_level
);

    // ****************************************************************
    // Decoding helpers.
    // ****************************************************************

    // Prefix rewrite of the addressing mode.
    function automatic oag_pkg::oag_mode_e conv(oag_pkg::oag_mode_e m,
                                                logic [7:0] p);
        logic ind;
        ind = (p == oag_pkg::INDIRECT_PREFIX) ||
              (p == oag_pkg::Y_INDIRECT_PREFIX);
        conv = m;
        if (ind) begin
            case (m)
                oag_pkg::OAG_DIR_S: conv = oag_pkg::OAG_IND_S;
                oag_pkg::OAG_DIR_L: conv = oag_pkg::OAG_IND_L;
                oag_pkg::OAG_IDX_S: conv = oag_pkg::OAG_IIX_S;
                oag_pkg::OAG_IDX_L: conv = oag_pkg::OAG_IIX_L;
                oag_pkg::OAG_REL_D: conv = oag_pkg::OAG_REL_I;
                oag_pkg::OAG_BIT_D: conv = oag_pkg::OAG_BIT_I;
                oag_pkg::OAG_BTR_D: conv = oag_pkg::OAG_BTR_I;
                default:            conv = m;
            endcase
        end
    endfunction

    // Modes with a two-byte address, offset or pointer.
    function automatic logic is_long(oag_pkg::oag_mode_e m);
        is_long = (m == oag_pkg::OAG_DIR_L) || (m == oag_pkg::OAG_IDX_L) ||
                  (m == oag_pkg::OAG_IND_L) || (m == oag_pkg::OAG_IIX_L);
    endfunction

    // Modes that read a pointer from page zero after the first byte.
    function automatic logic has_ptr(oag_pkg::oag_mode_e m);
        has_ptr = (m == oag_pkg::OAG_IND_S) || (m == oag_pkg::OAG_IND_L) ||
                  (m == oag_pkg::OAG_IIX_S) || (m == oag_pkg::OAG_IIX_L) ||
                  (m == oag_pkg::OAG_REL_I) || (m == oag_pkg::OAG_BIT_I) ||
                  (m == oag_pkg::OAG_BTR_I);
    endfunction

    // ****************************************************************
    // Sequencer.
    // ****************************************************************

    oag_pkg::oag_state_s r;
    oag_pkg::oag_state_s n;
    oag_pkg::oag_mode_e  cm;
    logic                ack;
    logic [7:0]          rb;
    logic [8:0]          sum9;

    assign cm  = conv(req.mode, req.prefix);
    assign ack = mem_req && mem_ack;
    // Relative offset: own byte for bit branches, else the fetched byte.
    assign rb  = (r.mode == oag_pkg::OAG_BTR_D ||
                  r.mode == oag_pkg::OAG_BTR_I) ? r.off : r.val[7:0];
    assign sum9 = {1'b0, r.val[7:0]} + {1'b0, r.idx};

    // Next state; fetched bytes shift into the value register, except the bit-branch offset byte.
    always_comb begin
        n = r;
        n.done = 1'b0;
        case (r.st)
            oag_pkg::OAG_IDLE: begin
                if (req_valid) begin
                    n.mode = cm;
                    // Either Y prefix picks Y; 91h also makes it indirect.
                    n.idx = (req.prefix == oag_pkg::Y_INDIRECT_PREFIX ||
                             req.prefix == oag_pkg::Y_INDEX_PREFIX)
                            ? req.y : req.x;
                    n.pc = req.pc;
                    n.val = 16'h0000;
                    n.off = 8'h00;
                    n.nb = 2'h0;
                    n.illegal = req.mm_op && is_long(cm);
                    if (req.irq_op == oag_pkg::OAG_SET_IRQ_MASK_OP)
                        n.irq = oag_pkg::IRQ_LVL_SET;
                    else if (req.irq_op == oag_pkg::OAG_CLEAR_IRQ_MASK_OP)
                        n.irq = oag_pkg::IRQ_LVL_CLR;
                    if (n.illegal || cm == oag_pkg::OAG_INH ||
                        cm == oag_pkg::OAG_IDX_0)
                        n.st = oag_pkg::OAG_CALC;
                    else
                        n.st = oag_pkg::OAG_F1;
                end
            end
            oag_pkg::OAG_F1: begin
                if (ack) begin
                    n.val = {r.val[7:0], mem_rdata};
                    n.ptr = mem_rdata;
                    n.pc = r.pc + 16'h0001;
                    n.nb = r.nb + 2'h1;
                    if (has_ptr(r.mode))
                        n.st = oag_pkg::OAG_P1;
                    else if (r.mode == oag_pkg::OAG_DIR_L ||
                             r.mode == oag_pkg::OAG_IDX_L ||
                             r.mode == oag_pkg::OAG_BTR_D)
                        n.st = oag_pkg::OAG_F2;
                    else
                        n.st = oag_pkg::OAG_CALC;
                end
            end
            oag_pkg::OAG_F2: begin
                if (ack) begin
                    n.pc = r.pc + 16'h0001;
                    n.nb = r.nb + 2'h1;
                    if (r.mode == oag_pkg::OAG_BTR_D ||
                        r.mode == oag_pkg::OAG_BTR_I)
                        n.off = mem_rdata;
                    else
                        n.val = {r.val[7:0], mem_rdata};
                    n.st = oag_pkg::OAG_CALC;
                end
            end
            oag_pkg::OAG_P1: begin
                if (ack) begin
                    n.val = {r.val[7:0], mem_rdata};
                    if (r.mode == oag_pkg::OAG_IND_L ||
                        r.mode == oag_pkg::OAG_IIX_L)
                        n.st = oag_pkg::OAG_P2;
                    else if (r.mode == oag_pkg::OAG_BTR_I)
                        n.st = oag_pkg::OAG_F2;
                    else
                        n.st = oag_pkg::OAG_CALC;
                end
            end
            oag_pkg::OAG_P2: begin
                if (ack) begin
                    n.val = {r.val[7:0], mem_rdata};
                    n.st = oag_pkg::OAG_CALC;
                end
            end
            oag_pkg::OAG_CALC: begin
                n.res.target = r.pc + {{8{rb[7]}}, rb};
                n.res.imm = r.val[7:0];
                n.res.next_pc = r.pc;
                n.res.nbytes = r.nb;
                n.res.illegal = r.illegal;
                case (r.mode)
                    oag_pkg::OAG_IMM: n.res.ea = r.pc - 16'h0001;
                    oag_pkg::OAG_DIR_S, oag_pkg::OAG_IND_S,
                    oag_pkg::OAG_BIT_D, oag_pkg::OAG_BIT_I,
                    oag_pkg::OAG_BTR_D, oag_pkg::OAG_BTR_I:
                        n.res.ea = {8'h00, r.val[7:0]};
                    oag_pkg::OAG_DIR_L, oag_pkg::OAG_IND_L:
                        n.res.ea = r.val;
                    oag_pkg::OAG_IDX_0: n.res.ea = {8'h00, r.idx};
                    oag_pkg::OAG_IDX_S, oag_pkg::OAG_IIX_S:
                        n.res.ea = {7'h00, sum9};
                    oag_pkg::OAG_IDX_L, oag_pkg::OAG_IIX_L:
                        n.res.ea = r.val + {8'h00, r.idx};
                    oag_pkg::OAG_REL_D, oag_pkg::OAG_REL_I:
                        n.res.ea = n.res.target;
                    default: n.res.ea = 16'h0000;
                endcase
                if (r.illegal)
                    n.res.ea = 16'h0000;
                n.done = 1'b1;
                n.st = oag_pkg::OAG_IDLE;
            end
            default: n.st = oag_pkg::OAG_IDLE;
        endcase
    end

    // State register; the mask comes out of reset at the set level.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
            r.irq <= oag_pkg::IRQ_LVL_RST;
        end else begin
            r <= n;
        end
    end

    // ****************************************************************
    // Outputs.
    // ****************************************************************

    // Pointer reads stay in page zero; the second byte wraps there.
    always_comb begin
        mem_req = (r.st == oag_pkg::OAG_F1) || (r.st == oag_pkg::OAG_F2) ||
                  (r.st == oag_pkg::OAG_P1) || (r.st == oag_pkg::OAG_P2);
        if (r.st == oag_pkg::OAG_P1)
            mem_addr = {8'h00, r.ptr};
        else if (r.st == oag_pkg::OAG_P2)
            mem_addr = {8'h00, r.ptr + 8'h01};
        else
            mem_addr = r.pc;
    end

    assign req_ready = (r.st == oag_pkg::OAG_IDLE);
    assign res_valid = r.done;
    assign res       = r.res;
    assign irq_level = r.irq;

    // ****************************************************************
    // Assertions.
    // ****************************************************************

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_take;
        req_valid && req_ready;
    endsequence

    sequence s_take_inh;
        s_take ##0 (cm == oag_pkg::OAG_INH);
    endsequence

    property p_inh_short;
        s_take_inh |=> !mem_req ##1 (res_valid && res.nbytes == 2'h0);
    endproperty
    a_inh_short: assert property (p_inh_short)
        else $error("Inherent instruction fetched operand bytes.");
    property p_imm_len;
        res_valid && r.mode == oag_pkg::OAG_IMM |->
            res.nbytes == 2'h1 && res.ea == res.next_pc - 16'h0001;
    endproperty
    a_imm_len: assert property (p_imm_len)
        else $error("Immediate operand length or address wrong.");
    property p_dir_s;
        res_valid && r.mode == oag_pkg::OAG_DIR_S |->
            res.ea[15:8] == 8'h00 && res.nbytes == 2'h1;
    endproperty
    a_dir_s: assert property (p_dir_s)
        else $error("Short direct left page zero.");
    property p_long_two;
        res_valid && !res.illegal && (r.mode == oag_pkg::OAG_DIR_L ||
            r.mode == oag_pkg::OAG_IDX_L) |-> res.nbytes == 2'h2;
    endproperty
    a_long_two: assert property (p_long_two)
        else $error("Long mode did not take two bytes.");
    property p_idx0;
        res_valid && r.mode == oag_pkg::OAG_IDX_0 |->
            res.ea == {8'h00, r.idx} && res.nbytes == 2'h0;
    endproperty
    a_idx0: assert property (p_idx0)
        else $error("No-offset indexed address wrong.");
    property p_idx_s_range;
        res_valid && (r.mode == oag_pkg::OAG_IDX_S ||
            r.mode == oag_pkg::OAG_IIX_S) |->
            res.ea == {8'h00, r.val[7:0]} + {8'h00, r.idx} &&
            res.ea <= oag_pkg::IDX_S_MAX;
    endproperty
    a_idx_s_range: assert property (p_idx_s_range)
        else $error("Short indexed address wrong.");
    property p_ptr_page0;
        mem_req && (r.st == oag_pkg::OAG_P1 || r.st == oag_pkg::OAG_P2)
            |-> mem_addr[15:8] == 8'h00;
    endproperty
    a_ptr_page0: assert property (p_ptr_page0)
        else $error("Pointer read outside page zero.");
    property p_rel;
        res_valid && r.mode == oag_pkg::OAG_REL_D |->
            res.ea == res.next_pc + {{8{r.val[7]}}, r.val[7:0]};
    endproperty
    a_rel: assert property (p_rel)
        else $error("Relative target wrong.");

    property p_mm_long;
        s_take ##0 (req.mm_op && is_long(cm)) |=>
            !mem_req ##1 (res_valid && res.illegal);
    endproperty
    a_mm_long: assert property (p_mm_long)
        else $error("Long memory-to-memory op not flagged.");

    property p_irq_set;
        s_take ##0 (req.irq_op == oag_pkg::OAG_SET_IRQ_MASK_OP) |=>
            irq_level == 2'h3 [*2];
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("Mask not at level 3 after set.");

    property p_irq_clr;
        s_take ##0 (req.irq_op == oag_pkg::OAG_CLEAR_IRQ_MASK_OP) |=>
            irq_level == 2'h0;
    endproperty
    a_irq_clr: assert property (p_irq_clr)
        else $error("Mask not at level 0 after clear.");

    property p_y_prefix;
        s_take ##0 (req.prefix == oag_pkg::Y_INDEX_PREFIX) |=>
            r.idx == $past(req.y);
    endproperty
    a_y_prefix: assert property (p_y_prefix)
        else $error("Y prefix did not select Y.");

    property p_ind_prefix;
        s_take ##0 (req.prefix == oag_pkg::INDIRECT_PREFIX &&
            req.mode == oag_pkg::OAG_DIR_S) |=>
            r.mode == oag_pkg::OAG_IND_S;
    endproperty
    a_ind_prefix: assert property (p_ind_prefix)
        else $error("Indirect prefix did not convert mode.");

endmodule

// ### src/oag_pkg.sv
// ****************************************************************
// Shared types and constants of the operand address generator.
// ****************************************************************
package oag_pkg;

    // Seventeen operand addressing modes, given by the opcode decoder.
    typedef enum logic [4:0] {
        OAG_INH, OAG_IMM, OAG_DIR_S, OAG_DIR_L, OAG_IDX_0, OAG_IDX_S,
        OAG_IDX_L, OAG_IND_S, OAG_IND_L, OAG_IIX_S, OAG_IIX_L,
        OAG_REL_D, OAG_REL_I, OAG_BIT_D, OAG_BIT_I, OAG_BTR_D, OAG_BTR_I
    } oag_mode_e;

    // Interrupt mask operations carried by inherent instructions.
    typedef enum logic [1:0] {
        OAG_IRQ_NONE,
        OAG_SET_IRQ_MASK_OP,
        OAG_CLEAR_IRQ_MASK_OP
    } oag_irq_op_e;

    // Sequencer states, Gray coded in the order IDLE, F1, P1, P2, F2, CALC.
    typedef enum logic [2:0] {
        OAG_IDLE = 3'h0,
        OAG_F1   = 3'h1,
        OAG_P1   = 3'h3,
        OAG_P2   = 3'h2,
        OAG_F2   = 3'h6,
        OAG_CALC = 3'h7
    } oag_state_e;

    // Prefix byte values.
    localparam logic [7:0] Y_INDEX_PREFIX   = 8'h90;
    localparam logic [7:0] Y_INDIRECT_PREFIX = 8'h91;
    localparam logic [7:0] INDIRECT_PREFIX  = 8'h92;

    // Interrupt mask levels, mask reset value and short indexed limit.
    localparam logic [1:0] IRQ_LVL_SET = 2'h3;
    localparam logic [1:0] IRQ_LVL_CLR = 2'h0;
    localparam logic [1:0] IRQ_LVL_RST = 2'h3;
    localparam logic [15:0] IDX_S_MAX  = 16'h01fe;

    // One instruction handed over by the opcode decoder.
    typedef struct packed {
        oag_mode_e   mode;
        logic [7:0]  prefix;
        logic        mm_op;
        oag_irq_op_e irq_op;
        logic [15:0] pc;
        logic [7:0]  x;
        logic [7:0]  y;
    } oag_req_s;

    // Result of address generation.
    typedef struct packed {
        logic [15:0] ea;
        logic [15:0] target;
        logic [7:0]  imm;
        logic [15:0] next_pc;
        logic [1:0]  nbytes;
        logic        illegal;
    } oag_res_s;

    // Complete state of the generator.
    typedef struct packed {
        oag_state_e  st;
        oag_mode_e   mode;
        logic [7:0]  idx;
        logic [15:0] pc;
        logic [15:0] val;
        logic [7:0]  ptr;
        logic [7:0]  off;
        logic [1:0]  nb;
        logic        illegal;
        logic [1:0]  irq;
        logic        done;
        oag_res_s    res;
    } oag_state_s;

endpackage

// ### verif/oag_mem_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Behavioural model of the CPU memory bus seen by the generator.
// ****************************************************************
module oag_mem_model (
    // Clock and reset.
    input  wire logic        core_clk,
    input  wire logic        arst_n,
    // Read port driven by the generator.
    input  wire logic        mem_req,
    input  wire logic [15:0] mem_addr,
    output logic [7:0]       mem_rdata,
    output logic             mem_ack,
    // Wait states before each acknowledge, set by the bench.
    input  wire logic [3:0]  wait_cycles
);
    // Byte storage, loaded by the bench before reset is released.
    logic [7:0] mem [0:65535];
    logic [3:0] cnt_r;
    logic [7:0] junk_r;

    // Acknowledge once the wait count is used up; outside an
    // acknowledge the data lines carry a moving pattern, so a byte
    // sampled at the wrong edge never looks like the right one.
    assign mem_ack   = mem_req && (cnt_r == wait_cycles);
    assign mem_rdata = mem_ack ? mem[mem_addr] : junk_r;

    // Wait counter restarts after every byte and while idle.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r  <= 4'h0;
            junk_r <= 8'ha5;
        end else begin
            junk_r <= ~junk_r + 8'h3b;
            if (!mem_req || mem_ack) begin
                cnt_r <= 4'h0;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule

// ### verif/oag_addr_gen_bench.sv
`timescale 1ns/10ps
module oag_addr_gen_bench;
    // ****************************************************************
    // Types, signals and instances.
    // ****************************************************************
    // One table row: request fields beside the expected result.
    typedef struct packed {
        oag_pkg::oag_mode_e mode;
        logic [7:0]         pre;
        logic               mm;
        logic [15:0]        ea;
        logic [1:0]         nb;
        logic [2:0]         nrd;
    } oag_row_s;

    logic              core_clk;
    logic              arst_n;
    logic              req_valid;
    logic              req_ready;
    oag_pkg::oag_req_s req;
    logic              mem_req;
    logic [15:0]       mem_addr;
    logic [7:0]        mem_rdata;
    logic              mem_ack;
    logic              res_valid;
    oag_pkg::oag_res_s res;
    logic [1:0]        irq_level;
    logic [3:0]        wait_cycles;
    logic [1:0]        exp_lvl;
    int                failures = 0;
    int                total_checks = 0;
    int                cyc = 0;
    oag_row_s          rows [27];
    oag_row_s          hr;

    oag_addr_gen oag_addr_gen_i (
        .core_clk (core_clk), .arst_n (arst_n), .req_valid (req_valid),
        .req_ready (req_ready), .req (req), .mem_req (mem_req),
        .mem_addr (mem_addr), .mem_rdata (mem_rdata), .mem_ack (mem_ack),
        .res_valid (res_valid), .res (res), .irq_level (irq_level)
    );

    oag_mem_model oag_mem_model_i (
        .core_clk (core_clk), .arst_n (arst_n), .mem_req (mem_req),
        .mem_addr (mem_addr), .mem_rdata (mem_rdata), .mem_ack (mem_ack),
        .wait_cycles (wait_cycles)
    );

    // ****************************************************************
    // Clock, timeout and reporting.
    // ****************************************************************
    // Free-running 20 MHz clock.
    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;

    // The whole run needs under 400 cycles; a hang is cut off well after.
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            failures++;
            close_out();
        end
    end

    // Counts one comparison and reports a mismatch at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // ****************************************************************
    // Request driver and result checker.
    // ****************************************************************
    // Offers one request and holds it until the edge that takes it.
    task automatic issue(input oag_row_s r, input logic [15:0] pc,
                         input logic [1:0] irq, input logic [3:0] w);
        logic rdy;
        wait_cycles = w;
        req.mode = r.mode;
        req.prefix = r.pre;
        req.mm_op = r.mm;
        req.irq_op = oag_pkg::oag_irq_op_e'(irq);
        req.pc = pc;
        req.x = 8'h7f;
        req.y = 8'hff;
        req_valid = 1'b1;
        do begin
            rdy = req_ready;
            @(posedge core_clk);
            #1;
        end while (rdy !== 1'b1);
        req_valid = 1'b0;
    endtask

    // Runs one request to its result and compares the fields its mode defines.
    task automatic run(input oag_row_s r, input logic [15:0] pc,
                       input logic [1:0] irq, input logic [3:0] w);
        int   lat;
        logic ill;
        ill = r.mm && (r.mode inside {oag_pkg::OAG_DIR_L,
              oag_pkg::OAG_IDX_L, oag_pkg::OAG_IND_L, oag_pkg::OAG_IIX_L});
        issue(r, pc, irq, w);
        if (irq == 2'h1) exp_lvl = 2'h3;
        if (irq == 2'h2) exp_lvl = 2'h0;
        lat = 0;
        do begin
            @(posedge core_clk);
            #1;
            lat++;
        end while (res_valid !== 1'b1 && lat < 60);
        // Edges after the take: every byte fetched plus the result step.
        check(16'(lat), 16'(1 + r.nrd * (1 + w)));
        check(16'(res.illegal), 16'(ill));
        if (r.mode != oag_pkg::OAG_INH) begin
            check(res.ea, r.ea);
        end
        if (!ill) begin
            check(16'(res.nbytes), 16'(r.nb));
            check(res.next_pc, pc + 16'(r.nb));
        end
        if (r.mode inside {oag_pkg::OAG_REL_D, oag_pkg::OAG_REL_I}) begin
            check(res.target, r.ea);
        end
        if (r.mode inside {oag_pkg::OAG_BTR_D, oag_pkg::OAG_BTR_I}) begin
            check(res.target, 16'h1222);
        end
        if (r.mode == oag_pkg::OAG_IMM) begin
            check(16'(res.imm), 16'h0080);
        end
        check(16'(irq_level), 16'(exp_lvl));
    endtask

    // Outputs other than res held at their reset values while reset is low.
    task automatic rst_chk();
        check(16'({mem_req, res_valid, req_ready, irq_level}), 16'h0007);
        check(mem_addr, 16'h0000);
    endtask

    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    // Table at pc 1230h with x = 7fh and y = ffh; memory below.
    initial begin
        rows = '{
            '{oag_pkg::OAG_IMM,   8'h00, 1'h0, 16'h1230, 2'h1, 3'h1},
            '{oag_pkg::OAG_DIR_S, 8'h00, 1'h0, 16'h0080, 2'h1, 3'h1},
            '{oag_pkg::OAG_DIR_L, 8'h00, 1'h0, 16'h80f0, 2'h2, 3'h2},
            '{oag_pkg::OAG_IDX_0, 8'h00, 1'h0, 16'h007f, 2'h0, 3'h0},
            '{oag_pkg::OAG_IDX_0, 8'h90, 1'h0, 16'h00ff, 2'h0, 3'h0},
            '{oag_pkg::OAG_IDX_S, 8'h00, 1'h0, 16'h00ff, 2'h1, 3'h1},
            '{oag_pkg::OAG_IDX_S, 8'h90, 1'h0, 16'h017f, 2'h1, 3'h1},
            '{oag_pkg::OAG_IDX_L, 8'h90, 1'h0, 16'h81ef, 2'h2, 3'h2},
            '{oag_pkg::OAG_IND_S, 8'h00, 1'h0, 16'h00c4, 2'h1, 3'h2},
            '{oag_pkg::OAG_IND_L, 8'h00, 1'h0, 16'hc456, 2'h1, 3'h3},
            '{oag_pkg::OAG_IIX_S, 8'h00, 1'h0, 16'h0143, 2'h1, 3'h2},
            '{oag_pkg::OAG_IIX_S, 8'h91, 1'h0, 16'h01c3, 2'h1, 3'h2},
            '{oag_pkg::OAG_IIX_L, 8'h91, 1'h0, 16'hc555, 2'h1, 3'h3},
            '{oag_pkg::OAG_REL_D, 8'h00, 1'h0, 16'h11b1, 2'h1, 3'h1},
            '{oag_pkg::OAG_REL_I, 8'h00, 1'h0, 16'h11f5, 2'h1, 3'h2},
            '{oag_pkg::OAG_BIT_D, 8'h00, 1'h0, 16'h0080, 2'h1, 3'h1},
            '{oag_pkg::OAG_BIT_I, 8'h00, 1'h0, 16'h00c4, 2'h1, 3'h2},
            '{oag_pkg::OAG_BTR_D, 8'h00, 1'h0, 16'h0080, 2'h2, 3'h2},
            '{oag_pkg::OAG_BTR_I, 8'h00, 1'h0, 16'h00c4, 2'h2, 3'h3},
            '{oag_pkg::OAG_DIR_L, 8'h92, 1'h0, 16'hc456, 2'h1, 3'h3},
            '{oag_pkg::OAG_IDX_S, 8'h92, 1'h0, 16'h0143, 2'h1, 3'h2},
            '{oag_pkg::OAG_IDX_L, 8'h92, 1'h0, 16'hc4d5, 2'h1, 3'h3},
            '{oag_pkg::OAG_REL_D, 8'h92, 1'h0, 16'h11f5, 2'h1, 3'h2},
            '{oag_pkg::OAG_BTR_D, 8'h92, 1'h0, 16'h00c4, 2'h2, 3'h3},
            '{oag_pkg::OAG_DIR_S, 8'h92, 1'h0, 16'h00c4, 2'h1, 3'h2},
            '{oag_pkg::OAG_DIR_S, 8'h00, 1'h1, 16'h0080, 2'h1, 3'h1},
            '{oag_pkg::OAG_IDX_L, 8'h00, 1'h1, 16'h0000, 2'h0, 3'h0}};
        arst_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        wait_cycles = 4'h0;
        exp_lvl = 2'h3;
        oag_mem_model_i.mem[16'h1230] = 8'h80;
        oag_mem_model_i.mem[16'h1231] = 8'hf0;
        oag_mem_model_i.mem[16'h0080] = 8'hc4;
        oag_mem_model_i.mem[16'h0081] = 8'h56;
        oag_mem_model_i.mem[16'h2000] = 8'hff;
        oag_mem_model_i.mem[16'h00ff] = 8'h9a;
        oag_mem_model_i.mem[16'h0000] = 8'hbc;
        oag_mem_model_i.mem[16'h3000] = 8'hff;
        oag_mem_model_i.mem[16'h3001] = 8'hc0;
        oag_mem_model_i.mem[16'hffff] = 8'h7f;
        repeat (5) @(posedge core_clk);
        #1;
        rst_chk();
        arst_n = 1'b1;
        // Mask cleared, then set, so that each step moves the level.
        hr = '{oag_pkg::OAG_INH, 8'h00, 1'h0, 16'h0000, 2'h0, 3'h0};
        run(hr, 16'h1230, 2'h2, 4'h0);
        run(hr, 16'h1230, 2'h1, 4'h0);
        // Every mode but inherent back to back, with a prompt and a slow memory.
        for (int w = 0; w < 4; w += 3) begin
            foreach (rows[i]) begin
                run(rows[i], 16'h1230, 2'h0, 4'(w));
            end
        end
        // Pointer high byte at 00ffh, low byte wraps to 0000h.
        hr = '{oag_pkg::OAG_IND_L, 8'h00, 1'h0, 16'h9abc, 2'h1, 3'h3};
        run(hr, 16'h2000, 2'h0, 4'h1);
        // Long offset plus index wraps past ffffh.
        hr = '{oag_pkg::OAG_IDX_L, 8'h00, 1'h0, 16'h003f, 2'h2, 3'h2};
        run(hr, 16'h3000, 2'h0, 4'h0);
        // Program counter wraps from ffffh to 0000h.
        hr = '{oag_pkg::OAG_REL_D, 8'h00, 1'h0, 16'h007f, 2'h1, 3'h1};
        run(hr, 16'hffff, 2'h0, 4'h0);
        // Reset in mid-fetch abandons the read and restores the mask.
        issue(rows[2], 16'h1230, 2'h2, 4'h6);
        repeat (3) begin
            @(posedge core_clk);
            #1;
        end
        check(16'(mem_req), 16'h0001);
        check(mem_addr, 16'h1230);
        check(16'(irq_level), 16'h0000);
        arst_n = 1'b0;
        #1;
        rst_chk();
        @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        exp_lvl = 2'h3;
        run(rows[2], 16'h1230, 2'h0, 4'h0);
        close_out();
    end
endmodule
